// file: core/sec_pkg.sv
// Overview of operation
// - one opcode byte, msb first, unknown deselects
// - opcodes 06 04 05 01 03 02 decoded
// - sample input on rise, shift output on fall
// - guard bits: none, quarter, half, whole
// - lock bit plus low guard pin freezes status
// - guard bits 3:2 set protected area
// - latch bit 1; writes refused while clear
// - latch clears on reset, drop, clear, completion
// - busy bit 0 high only while programming
// - latch-set acts only after exactly 8 clocks
// - latch-clear acts only after exactly 8 clocks
// - status byte repeats until deselect
// - programming shows old nonvolatile bits, live others
// - status write touches bits 7,3,2; 6:4 zero
// - status write starts only after exactly 16 clocks
// - read loads address, increments, wraps around
// - read ignored while programming
// - page write 32 bytes, low 5 bits wrap
// - memory write starts after 24 + 8m clocks
// - write refused: no latch, busy, protected
package sec_pkg;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_MEM_RD = 8'h03;
    localparam logic [7:0] OP_MEM_WR = 8'h02;
    // status bit positions
    localparam int BIT_LOCK = 7;
    localparam int BIT_GUARD_HI = 3;
    localparam int BIT_GUARD_LO = 2;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BUSY = 0;
    // clock counts that end the opcode, the status or high address byte, and the address
    localparam logic [15:0] CNT_OPCODE = 16'h0008;
    localparam logic [15:0] CNT_STATUS = 16'h0010;
    localparam logic [15:0] CNT_ADDR = 16'h0018;
    localparam int ADDR_W = 12;
    localparam int MEM_DEPTH = 4096;
    localparam int PAGE_BYTES = 32;
    localparam logic [7:0] MEM_RESET = 8'hFF;
    localparam logic [3:0] SYNC_RESET = 4'h9; // cs, sck, si, guard pin
    // self-timed programming
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_US = 5000;
    localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    // host side
    localparam int SCK_HALF_CYCLES = 13;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXD = 8'h04;
    localparam logic [7:0] REG_RXD = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_PINS = 8'h10;
    localparam logic [5:0] MAX_EXTRA_BITS = 6'h20;
endpackage : sec_pkg

// file: core/sec_spi_if.sv
`timescale 1ns/1ps
interface sec_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic guard_n;
    logic miso_o;
    logic miso_oe;
    wire miso;
    // released line shows the inverse of the last bit, so stale data cannot pass for valid
    assign miso = miso_oe ? miso_o : ~miso_o;
    modport dev (input cs_n, input sck, input mosi, input guard_n, output miso_o,
        output miso_oe);
    modport host (output cs_n, output sck, output mosi, output guard_n, input miso);
endinterface : sec_spi_if

// file: core/sec_spi_host.sv
`timescale 1ns/1ps
module sec_spi_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sec_spi_if.host spi
);
    import sec_pkg::*;
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LOW = 3'b001,
        HS_HIGH = 3'b010,
        HS_TRAIL = 3'b011,
        HS_GAP = 3'b100
    } sec_hstate_t;

    sec_hstate_t st_q;
    logic [39:0] sh_q;
    logic [5:0] left_q;
    logic [4:0] div_q;
    logic [31:0] txd_q;
    logic [31:0] rxd_q;
    logic guard_q;
    logic cs_q;
    logic sck_q;
    logic miso_m_q;
    logic miso_s_q;
    logic [31:0] prdata_q;
    logic mapped;
    logic wr_en;
    logic half_done;

    assign wr_en = psel & penable & pwrite;
    assign half_done = div_q == 5'(SCK_HALF_CYCLES - 1);
    assign mapped = paddr == REG_CTRL || paddr == REG_TXD || paddr == REG_RXD ||
        paddr == REG_STAT || paddr == REG_PINS;
    // answer every access in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;
    assign spi.cs_n = cs_q;
    assign spi.sck = sck_q;
    assign spi.mosi = sh_q[39];
    assign spi.guard_n = guard_q;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                REG_TXD: prdata_q <= txd_q;
                REG_RXD: prdata_q <= rxd_q;
                REG_STAT: prdata_q <= {31'h0000_0000, st_q != HS_IDLE};
                REG_PINS: prdata_q <= {31'h0000_0000, guard_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // software-held registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_q <= 32'h0000_0000;
            guard_q <= 1'b1;
        end else if (wr_en) begin
            if (paddr == REG_TXD) txd_q <= pwdata;
            if (paddr == REG_PINS) guard_q <= pwdata[0];
        end
    end

    // returning data passes two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            miso_m_q <= spi.miso;
            miso_s_q <= miso_m_q;
        end
    end

    // frame sequencer; a ctrl write while busy is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= HS_IDLE;
            sh_q <= 40'h00_0000_0000;
            left_q <= 6'h00;
            div_q <= 5'h00;
            rxd_q <= 32'h0000_0000;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            div_q <= half_done ? 5'h00 : div_q + 5'h01;
            case (st_q)
                HS_IDLE: begin
                    div_q <= 5'h00;
                    if (wr_en && paddr == REG_CTRL) begin
                        sh_q <= {pwdata[7:0], txd_q};
                        left_q <= (pwdata[13:8] > MAX_EXTRA_BITS) ? 6'd40 :
                            6'd8 + pwdata[13:8];
                        cs_q <= 1'b0;
                        st_q <= HS_LOW;
                    end
                end
                HS_LOW: if (half_done) begin
                    sck_q <= 1'b1;
                    rxd_q <= {rxd_q[30:0], miso_s_q};
                    st_q <= HS_HIGH;
                end
                HS_HIGH: if (half_done) begin
                    sck_q <= 1'b0;
                    left_q <= left_q - 6'h01;
                    sh_q <= {sh_q[38:0], 1'b0};
                    st_q <= (left_q == 6'h01) ? HS_TRAIL : HS_LOW;
                end
                HS_TRAIL: if (half_done) begin
                    cs_q <= 1'b1;
                    st_q <= HS_GAP;
                end
                HS_GAP: if (half_done) st_q <= HS_IDLE;
                default: st_q <= HS_IDLE;
            endcase
        end
    end
endmodule : sec_spi_host

// file: core/sec_eeprom_dev.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module sec_eeprom_dev #(
    parameter int unsigned PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic supply_drop,
    output logic busy_o,
    output logic [7:0] status_o,
    sec_spi_if.dev spi
);
    import sec_pkg::*;
    typedef enum logic [1:0] {
        DS_OPC = 2'b00,
        DS_ARG = 2'b01,
        DS_DROP = 2'b10
    } sec_dstate_t;

    logic [3:0] in_m_q;
    logic [3:0] in_s_q;
    logic cs_d_q;
    logic sck_d_q;
    sec_dstate_t ph_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_n;
    logic [7:0] sh_q;
    logic [7:0] nxt;
    logic [7:0] op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] sr_data_q;
    logic wr_ok_q;
    logic data_seen_q;
    logic [7:0] pbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [ADDR_W-6:0] pg_q;
    logic lock_q;
    logic [1:0] guard_q;
    logic wel_q;
    logic busy_q;
    logic kind_sr_q;
    logic [7:0] pend_q;
    logic [31:0] pcnt_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] out_sh_q;
    logic miso_q;
    logic oe_q;
    logic sel;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic hw_lock;
    logic op_known;
    logic prot_hit;
    logic done;
    logic start_sr;
    logic start_mem;
    logic [7:0] status;
    logic [7:0] tx_byte;
    logic tx_active;
    logic [ADDR_W-1:0] new_addr;

    // pins cross into pclk; edges come from the second stage on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_m_q <= SYNC_RESET;
            in_s_q <= SYNC_RESET;
            cs_d_q <= 1'b1;
            sck_d_q <= 1'b0;
        end else begin
            in_m_q <= {spi.cs_n, spi.sck, spi.mosi, spi.guard_n};
            in_s_q <= in_m_q;
            cs_d_q <= in_s_q[3];
            sck_d_q <= in_s_q[2];
        end
    end

    assign sel = ~in_s_q[3];
    assign cs_rise = in_s_q[3] & ~cs_d_q;
    // input taken on rise, output moved on fall
    assign sck_rise = sel & in_s_q[2] & ~sck_d_q;
    assign sck_fall = sel & ~in_s_q[2] & sck_d_q;
    assign cnt_n = cnt_q + 16'h0001;
    assign nxt = {sh_q[6:0], in_s_q[1]};
    assign new_addr = {addr_q[ADDR_W-1:8], nxt};
    // lock bit with low guard pin freezes status
    assign hw_lock = lock_q & ~in_s_q[0];
    assign op_known = nxt == OP_LATCH_SET || nxt == OP_LATCH_CLR || nxt == OP_STAT_RD ||
        nxt == OP_STAT_WR || nxt == OP_MEM_RD || nxt == OP_MEM_WR;
    // upper quarter, upper half or whole array
    assign prot_hit = (guard_q == 2'b11) || (guard_q == 2'b10 && new_addr[ADDR_W-1]) ||
        (guard_q == 2'b01 && new_addr[ADDR_W-1:ADDR_W-2] == 2'b11);
    // nonvolatile bits are the committed copy; latch and busy live
    assign status = {lock_q, 3'b000, guard_q, wel_q, busy_q};
    assign tx_byte = (op_q == OP_STAT_RD) ? status : mem_q[addr_q];
    assign tx_active = ph_q == DS_ARG && ((op_q == OP_STAT_RD && cnt_q >= CNT_OPCODE) ||
        (op_q == OP_MEM_RD && cnt_q >= CNT_ADDR));
    // exactly 16 clocks, latch set, not locked, idle
    assign start_sr = cs_rise && ph_q == DS_ARG && op_q == OP_STAT_WR &&
        cnt_q == CNT_STATUS && wel_q && !busy_q && !hw_lock;
    // 24 + 8m clocks with at least one data byte
    assign start_mem = cs_rise && ph_q == DS_ARG && op_q == OP_MEM_WR && wr_ok_q &&
        data_seen_q && cnt_q[2:0] == 3'b000;
    assign done = busy_q && pcnt_q == PROG_CYCLES - 1;
    // output only while selected and in a read data phase
    assign spi.miso_oe = oe_q & sel;
    assign spi.miso_o = miso_q;
    assign busy_o = busy_q;
    assign status_o = status;

    // frame receive and transmit; phase, count, data flag and output enable restart on deselect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= DS_OPC;
            cnt_q <= 16'h0000;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= '0;
            sr_data_q <= 8'h00;
            wr_ok_q <= 1'b0;
            data_seen_q <= 1'b0;
            out_sh_q <= 8'h00;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!sel) begin
            ph_q <= DS_OPC;
            cnt_q <= 16'h0000;
            data_seen_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (sck_rise) begin
            cnt_q <= cnt_n;
            sh_q <= nxt;
            case (ph_q)
                DS_OPC: if (cnt_n == CNT_OPCODE) begin
                    op_q <= nxt;
                    // no latch or busy refuses the write
                    wr_ok_q <= wel_q & ~busy_q;
                    // unknown opcode, or read while busy, drops out
                    ph_q <= (op_known && !(nxt == OP_MEM_RD && busy_q)) ? DS_ARG : DS_DROP;
                end
                DS_ARG: if (cnt_n[2:0] == 3'b000) begin
                    if (cnt_n == CNT_STATUS) begin
                        sr_data_q <= nxt;
                        addr_q[ADDR_W-1:8] <= nxt[ADDR_W-9:0];
                    end else if (cnt_n == CNT_ADDR) begin
                        addr_q <= new_addr;
                        if (op_q == OP_MEM_WR && prot_hit) wr_ok_q <= 1'b0;
                    end else if (cnt_n > CNT_ADDR && op_q == OP_MEM_WR && wr_ok_q) begin
                        // only the low 5 bits advance
                        data_seen_q <= 1'b1;
                        addr_q[4:0] <= addr_q[4:0] + 5'h01;
                    end
                end
                DS_DROP: ;
                default: ph_q <= DS_DROP;
            endcase
        end else if (sck_fall && tx_active) begin
            oe_q <= 1'b1;
            if (cnt_q[2:0] == 3'b000) begin
                // status byte reloaded at every byte boundary
                miso_q <= tx_byte[7];
                out_sh_q <= {tx_byte[6:0], 1'b0};
                // next address, wrapping at the top
                if (op_q == OP_MEM_RD) addr_q <= addr_q + 1'b1;
            end else begin
                miso_q <= out_sh_q[7];
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    // page buffer; a frame that may write clears the old page first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                pbuf_q[i] <= 8'h00;
            end
        end else if (sck_rise && sel && ph_q == DS_OPC && cnt_n == CNT_OPCODE &&
                nxt == OP_MEM_WR && !busy_q) begin
            mask_q <= '0;
        end else if (sck_rise && sel && ph_q == DS_ARG && op_q == OP_MEM_WR && wr_ok_q &&
                cnt_n > CNT_ADDR && cnt_n[2:0] == 3'b000) begin
            pbuf_q[addr_q[4:0]] <= nxt;
            mask_q[addr_q[4:0]] <= 1'b1;
        end
    end

    // self-timed programming; a supply drop abandons it uncommitted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            kind_sr_q <= 1'b0;
            pend_q <= 8'h00;
            pcnt_q <= 32'h0000_0000;
            pg_q <= '0;
        end else if (supply_drop) begin
            busy_q <= 1'b0;
        end else if (start_sr || start_mem) begin
            busy_q <= 1'b1;
            kind_sr_q <= start_sr;
            pend_q <= sr_data_q;
            pg_q <= addr_q[ADDR_W-1:5];
            pcnt_q <= 32'h0000_0000;
        end else if (busy_q) begin
            // counter decides the end of programming
            pcnt_q <= pcnt_q + 32'h0000_0001;
            if (done) busy_q <= 1'b0;
        end
    end

    // committed status bits, changed only at the end of programming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
            guard_q <= 2'b00;
        end else if (done && kind_sr_q && !supply_drop) begin
            // only lock and guard bits are taken
            lock_q <= pend_q[BIT_LOCK];
            guard_q <= pend_q[BIT_GUARD_HI:BIT_GUARD_LO];
        end
    end

    // array commit; one flop word per address keeps reads single-cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= MEM_RESET;
            end
        end else if (done && !kind_sr_q && !supply_drop) begin
            // array updated when the counter expires
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i]) mem_q[{pg_q, 5'(i)}] <= pbuf_q[i];
            end
        end
    end

    // write-enable latch; a latch-set closing with completion wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel_q <= 1'b0;
        end else if (supply_drop) begin
            wel_q <= 1'b0;
        end else if (cs_rise && ph_q == DS_ARG && cnt_q == CNT_OPCODE &&
                op_q == OP_LATCH_SET) begin
            wel_q <= 1'b1;
        end else if (cs_rise && ph_q == DS_ARG && cnt_q == CNT_OPCODE &&
                op_q == OP_LATCH_CLR) begin
            wel_q <= 1'b0;
        end else if (done) begin
            wel_q <= 1'b0;
        end
    end
endmodule : sec_eeprom_dev

// file: testbench/sec_spi_sva.sv
`timescale 1ns/1ps
module sec_spi_sva #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic busy_o,
    input wire logic [7:0] status_o
);
    logic [31:0] busy_cnt_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles spent busy; a counter because the cycle can outgrow any repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_q <= '0;
        end else if (busy_o) begin
            busy_cnt_q <= busy_cnt_q + 32'd1;
        end else begin
            busy_cnt_q <= '0;
        end
    end
    // output released once the select has been high past the sync delay
    oe_desel_a: assert property (cs_n [*6] |-> !miso_oe)
        else $error("data output driven while deselected");
    // output moves only in the low half of the serial clock
    miso_edge_a: assert property ($changed(miso_o) && miso_oe && $past(miso_oe) |-> !sck)
        else $error("data output changed outside the low clock phase");
    // the latch sets only once the frame has closed
    latch_rise_a: assert property ($rose(status_o[1]) |-> cs_n && $past(cs_n, 2))
        else $error("latch set while still selected");
    // programming starts at deselect and needs the latch
    busy_start_a: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 2) && status_o[1])
        else $error("programming started without deselect or latch");
    // completion clears the latch on the same edge
    busy_end_a: assert property ($fell(busy_o) |-> !status_o[1])
        else $error("latch still set after programming ended");
    // programming lasts the configured count
    busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_q >= PROG_CYCLES - 1 && busy_cnt_q <= PROG_CYCLES + 1)
        else $error("programming length differs from the configured count");
    busy_bound_a: assert property (busy_o |-> busy_cnt_q <= PROG_CYCLES + 1)
        else $error("programming overran the configured count");
    // nonvolatile bits frozen while programming
    nv_hold_a: assert property (busy_o && $past(busy_o) |-> $stable({status_o[7], status_o[3:2]}))
        else $error("nonvolatile status bits moved during programming");
    zero_bits_a: assert property (status_o[6:4] == 3'b000)
        else $error("unused status bits not zero");
    busy_bit_a: assert property (status_o[0] == busy_o)
        else $error("busy bit disagrees with busy output");
endmodule : sec_spi_sva

// file: testbench/test_spi_eeprom_command_core.sv
`timescale 1ns/1ps
module test_spi_eeprom_command_core;
    import sec_pkg::*;
    localparam int unsigned PROG = 1500;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic supply_drop = 1'b0;
    logic busy_o;
    logic [7:0] status_o;
    logic oe_seen;
    logic [31:0] rx;
    int err_count = 0;
    int tests_run = 0;
    // long enough that a status read fits inside a programming cycle
    always #2.5 pclk = ~pclk;
    sec_spi_if i_sec_spi_if();
    sec_spi_host i_sec_spi_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi(i_sec_spi_if));
    sec_eeprom_dev #(.PROG_CYCLES(PROG)) i_sec_eeprom_dev (.pclk(pclk), .presetn(presetn),
        .supply_drop(supply_drop), .busy_o(busy_o), .status_o(status_o),
        .spi(i_sec_spi_if));
    sec_spi_sva #(.PROG_CYCLES(PROG)) i_sec_spi_sva (.pclk(pclk), .presetn(presetn),
        .cs_n(i_sec_spi_if.cs_n), .sck(i_sec_spi_if.sck), .miso_o(i_sec_spi_if.miso_o),
        .miso_oe(i_sec_spi_if.miso_oe), .busy_o(busy_o), .status_o(status_o));

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic hang(input string nm);
        $display("MISMATCH %s expected done seen timeout", nm);
        err_count++;
        summarize();
    endtask : hang

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) hang("pready");
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // one serial frame: opcode plus n further clocks carrying tx from bit 31
    task automatic xfer(input logic [7:0] op, input logic [5:0] n, input logic [31:0] tx);
        logic [31:0] q;
        logic e;
        int k;
        oe_seen = 1'b0;
        apb(1'b1, REG_TXD, tx, q, e);
        apb(1'b1, REG_CTRL, {18'h0, n, op}, q, e);
        for (k = 0; k < 2000; k++) begin
            apb(1'b0, REG_STAT, 32'h0, q, e);
            if (i_sec_spi_if.miso_oe === 1'b1) oe_seen = 1'b1;
            if (q[0] === 1'b0) break;
        end
        if (k == 2000) hang("frame");
        apb(1'b0, REG_RXD, 32'h0, rx, e);
    endtask : xfer

    task automatic wait_idle;
        int k;
        for (k = 0; k < 4000 && busy_o !== 1'b0; k++) @(posedge pclk);
        if (k == 4000) hang("busy");
    endtask : wait_idle

    task automatic t_reset;
        logic [31:0] q;
        logic e;
        chk("status reset", 32'h0, {24'h0, status_o});
        chk("oe reset", 32'h0, {31'h0, i_sec_spi_if.miso_oe});
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, REG_PINS, 32'h0, q, e);
        chk("pins reset", 32'h1, {31'h0, q[0]});
    endtask : t_reset

    task automatic t_latch;
        xfer(OP_LATCH_SET, 6'd1, 32'h0);
        chk("set 9 clocks", 32'h0, {31'h0, status_o[1]});
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        chk("set 8 clocks", 32'h1, {31'h0, status_o[1]});
        xfer(OP_STAT_RD, 6'd16, 32'h0);
        chk("status repeat", 32'h0202, {16'h0, rx[15:0]});
        xfer(OP_LATCH_CLR, 6'd8, 32'h0);
        chk("clear 16 clocks", 32'h1, {31'h0, status_o[1]});
        xfer(8'hFF, 6'd8, 32'hFFFF_FFFF);
        chk("unknown opcode", 32'h2, {30'h0, status_o[1], oe_seen});
        xfer(OP_LATCH_CLR, 6'd0, 32'h0);
        chk("clear 8 clocks", 32'h0, {31'h0, status_o[1]});
    endtask : t_latch

    task automatic t_status;
        xfer(OP_STAT_WR, 6'd8, 32'hFF00_0000);
        chk("cmd_status_write no latch", 32'h00, {24'h0, status_o});
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        xfer(OP_STAT_WR, 6'd9, 32'hFF00_0000);
        chk("cmd_status_write 17 clocks", 32'h02, {24'h0, status_o});
        xfer(OP_STAT_WR, 6'd8, 32'hFF00_0000);
        chk("busy after cmd_status_write", 32'h1, {31'h0, busy_o});
        xfer(OP_STAT_RD, 6'd8, 32'h0);
        chk("status mid write", 32'h03, {24'h0, rx[7:0]});
        wait_idle();
        chk("status after cmd_status_write", 32'h8C, {24'h0, status_o});
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        xfer(OP_STAT_WR, 6'd8, 32'h8000_0000);
        wait_idle();
        chk("lock only", 32'h80, {24'h0, status_o});
    endtask : t_status

    task automatic t_lock;
        logic [31:0] q;
        logic e;
        apb(1'b1, REG_PINS, 32'h0, q, e);
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        xfer(OP_STAT_WR, 6'd8, 32'h0000_0000);
        chk("locked cmd_status_write", 32'h82, {24'h0, status_o});
        apb(1'b1, REG_PINS, 32'h1, q, e);
        xfer(OP_STAT_WR, 6'd8, 32'h0400_0000);
        wait_idle();
        chk("unlocked cmd_status_write", 32'h04, {24'h0, status_o});
    endtask : t_lock

    task automatic t_mem;
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        xfer(OP_MEM_WR, 6'd32, 32'h0C10_AA55);
        chk("protected write", 32'h06, {24'h0, status_o});
        xfer(OP_MEM_WR, 6'd32, 32'h001F_AA55);
        chk("page write busy", 32'h1, {31'h0, busy_o});
        xfer(OP_MEM_RD, 6'd24, 32'h001F_0000);
        chk("read while busy", 32'h0, {31'h0, oe_seen});
        wait_idle();
        chk("latch after write", 32'h0, {31'h0, status_o[1]});
        xfer(OP_MEM_RD, 6'd32, 32'h001F_0000);
        chk("sequential read", 32'hAAFF, {16'h0, rx[15:0]});
        xfer(OP_MEM_RD, 6'd32, 32'h0FFF_0000);
        chk("read wrap page wrap", 32'hFF55, {16'h0, rx[15:0]});
        xfer(OP_LATCH_SET, 6'd0, 32'h0);
        xfer(OP_MEM_WR, 6'd16, 32'h0100_0000);
        chk("write 24 clocks", 32'h0, {31'h0, busy_o});
        xfer(OP_MEM_WR, 6'd20, 32'h0100_1200);
        chk("write 28 clocks", 32'h06, {24'h0, status_o});
        xfer(OP_MEM_RD, 6'd24, 32'h0100_0000);
        chk("cancelled untouched", 32'hFF, {24'h0, rx[7:0]});
    endtask : t_mem

    task automatic t_drop;
        supply_drop <= 1'b1;
        repeat (4) @(posedge pclk);
        supply_drop <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("latch after drop", 32'h04, {24'h0, status_o});
    endtask : t_drop

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_latch();
        t_status();
        t_lock();
        t_mem();
        t_drop();
        summarize();
    end
endmodule : test_spi_eeprom_command_core
